// >>> verilog/fhc_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module fhc_host_ctrl import fhc_pkg::*; (
    input  wire logic       clk,
    input  wire logic       reset,

    // ==========================================================
    // Parallel control port
    input  wire logic       host_sel,
    input  wire logic       host_wr,
    input  wire logic       host_rd,
    input  wire logic [3:0] host_addr,
    input  wire logic [7:0] host_wdata,
    output logic [7:0]      host_rdata,
    output logic            int_n,
    input  wire logic       other_irq,

    // ==========================================================
    // Receive engine status
    input  wire logic       rx_packet_start,
    input  wire logic       rx_msg_good,
    input  wire logic       rx_crc_error,
    input  wire logic       rx_overrun,
    input  wire logic       rx_abort_seen,
    input  wire logic       rx_fifo_half_full,
    input  wire logic       rx_fifo_not_empty,
    input  wire logic       rx_fifo_empty,
    input  wire logic       opening_byte_flag,
    input  wire logic       closing_byte_flag,
    input  wire logic       packet_good,
    input  wire logic       code_detect_live,
    input  wire logic [5:0] rx_code,

    // ==========================================================
    // Transmit engine
    input  wire logic       tx_last_byte_sent,
    input  wire logic       tx_underrun,
    output logic [7:0]      tx_byte,
    output logic            tx_byte_valid,
    input  wire logic       tx_byte_ready,

    // ==========================================================
    // Controls toward the engines
    output logic            rx_code_reset,
    output logic            rx_packet_reset,
    output logic            tx_packet_reset,
    output logic            tx_abort,
    output logic [7:0]      idle_pattern,
    output logic            tx_end_of_message,
    output logic            zero_stuff_defeat,
    output logic            crc_gen_defeat,
    output logic [5:0]      tx_code,
    output logic            fdl_enable,
    output logic            send_code
);

    // ==========================================================
    // Decode

    function automatic logic wr_at(input logic sel, input logic wr,
                                   input logic [3:0] addr, input logic [3:0] ofs);
        return sel && wr && (addr == ofs);
    endfunction

    logic       wr_ctl;
    logic       wr_status;
    logic       wr_mask;
    logic       wr_rx_info;
    logic       wr_rx_code;
    logic       wr_tx_info;
    logic       wr_tx_code;
    logic       rd_any;

    assign wr_ctl     = wr_at(host_sel, host_wr, host_addr, OFS_CONTROL);
    assign wr_status  = wr_at(host_sel, host_wr, host_addr, OFS_STATUS);
    assign wr_mask    = wr_at(host_sel, host_wr, host_addr, OFS_MASK);
    assign wr_rx_info = wr_at(host_sel, host_wr, host_addr, OFS_RX_INFO);
    assign wr_rx_code = wr_at(host_sel, host_wr, host_addr, OFS_RX_CODE);
    assign wr_tx_info = wr_at(host_sel, host_wr, host_addr, OFS_TX_INFO);
    assign wr_tx_code = wr_at(host_sel, host_wr, host_addr, OFS_TX_CODE);
    assign rd_any     = host_sel && host_rd;

    // ==========================================================
    // Registers

    logic [7:0] control;
    logic [7:0] ctl_prev;
    logic [7:0] ctl_rise;
    logic [7:0] event_mask;
    logic [7:0] code_ctl;
    logic       code_prev;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            control <= CONTROL_RST;
        end else if (wr_ctl) begin
            // A host write in the same cycle beats the engine's clear
            control <= host_wdata;
        end else if (tx_last_byte_sent) begin
            control[CTL_EOM] <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctl_prev <= CONTROL_RST;
        end else begin
            ctl_prev <= control;
        end
    end

    // Only a zero-to-one step acts; holding the bit high does nothing more
    assign ctl_rise = control & ~ctl_prev;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            event_mask <= MASK_RST;
        end else if (wr_mask) begin
            event_mask <= host_wdata;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            code_ctl <= TX_CODE_RST;
        end else if (wr_tx_code) begin
            code_ctl <= host_wdata;
        end
    end

    assign tx_code    = code_ctl[5:0];
    assign fdl_enable = code_ctl[6];
    assign send_code  = code_ctl[7];

    // ==========================================================
    // Control outputs

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_code_reset   <= 1'b0;
            rx_packet_reset <= 1'b0;
            tx_packet_reset <= 1'b0;
            tx_abort        <= 1'b0;
        end else begin
            rx_code_reset   <= ctl_rise[CTL_RX_CODE_RST];
            rx_packet_reset <= ctl_rise[CTL_RX_PKT_RST];
            tx_packet_reset <= ctl_rise[CTL_TX_PKT_RST];
            tx_abort        <= ctl_rise[CTL_ABORT];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idle_pattern <= FLAG_PATTERN;
        end else begin
            idle_pattern <= control[CTL_IDLE_SEL] ? IDLE_ONES : FLAG_PATTERN;
        end
    end

    assign tx_end_of_message = control[CTL_EOM];
    assign zero_stuff_defeat = control[CTL_ZS_DEFEAT];
    assign crc_gen_defeat    = control[CTL_CRC_DEFEAT];

    // ==========================================================
    // Transmit FIFO

    fhc_stream_if #(.W(FIFO_WIDTH)) tx_in ();
    fhc_stream_if #(.W(FIFO_WIDTH)) tx_out ();

    logic [4:0] tx_fill;
    logic       tx_flush;

    // Abort dumps queued bytes; a transmit reset does the same
    assign tx_flush     = ctl_rise[CTL_ABORT] || ctl_rise[CTL_TX_PKT_RST];
    assign tx_in.valid  = wr_at(host_sel, host_wr, host_addr, OFS_TX_DATA);
    assign tx_in.data   = host_wdata;
    assign tx_out.ready = tx_byte_ready;
    assign tx_byte      = tx_out.data;
    assign tx_byte_valid = tx_out.valid;

    fhc_fifo #(
        .W     (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk   (clk),
        .reset (reset),
        .flush (tx_flush),
        .wr    (tx_in),
        .rd    (tx_out),
        .count (tx_fill)
    );

    // ==========================================================
    // Status events

    logic       code_cos;
    logic       pkt_end;
    logic [7:0] hsr_evt;
    logic [7:0] rx_info_evt;
    logic [7:0] rx_code_evt;
    logic [7:0] tx_info_evt;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            code_prev <= 1'b0;
        end else begin
            code_prev <= code_detect_live;
        end
    end

    assign code_cos = code_detect_live ^ code_prev;
    assign pkt_end  = rx_msg_good || rx_crc_error || rx_overrun || rx_abort_seen;

    // Four positions latch, the FIFO levels are live
    assign hsr_evt = {code_cos, pkt_end, rx_packet_start, rx_fifo_half_full,
                      rx_fifo_not_empty, (tx_fill < FIFO_HALF), tx_in.ready,
                      tx_last_byte_sent};

    assign rx_info_evt = {4'h0, packet_good, closing_byte_flag,
                          opening_byte_flag, rx_fifo_empty};
    assign rx_code_evt = {code_detect_live & ~code_prev, code_detect_live, rx_code};
    assign tx_info_evt = {3'h0, tx_underrun, !tx_in.ready, tx_in.ready,
                          (tx_fill < FIFO_HALF), (tx_fill == 5'h00)};

    logic [7:0] hsr_val;
    logic [7:0] rx_info_val;
    logic [7:0] rx_code_val;
    logic [7:0] tx_info_val;
    logic       hsr_pend;

    fhc_status_cell #(.LATCH_BITS(HSR_LATCH)) u_hsr (
        .clk        (clk),
        .reset      (reset),
        .event_in   (hsr_evt),
        .mask_wr    (wr_status),
        .wmask      (host_wdata),
        .irq_mask   (event_mask),
        .read_value (hsr_val),
        .pending    (hsr_pend)
    );

    fhc_status_cell #(.LATCH_BITS(RX_INFO_LATCH)) u_rx_info (
        .clk        (clk),
        .reset      (reset),
        .event_in   (rx_info_evt),
        .mask_wr    (wr_rx_info),
        .wmask      (host_wdata),
        .irq_mask   (8'h00),
        .read_value (rx_info_val),
        .pending    ()
    );

    fhc_status_cell #(.LATCH_BITS(RX_CODE_LATCH)) u_rx_code (
        .clk        (clk),
        .reset      (reset),
        .event_in   (rx_code_evt),
        .mask_wr    (wr_rx_code),
        .wmask      (host_wdata),
        .irq_mask   (8'h00),
        .read_value (rx_code_val),
        .pending    ()
    );

    fhc_status_cell #(.LATCH_BITS(TX_INFO_LATCH)) u_tx_info (
        .clk        (clk),
        .reset      (reset),
        .event_in   (tx_info_evt),
        .mask_wr    (wr_tx_info),
        .wmask      (host_wdata),
        .irq_mask   (8'h00),
        .read_value (tx_info_val),
        .pending    ()
    );

    // ==========================================================
    // Interrupt and read data

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            int_n <= 1'b1;
        end else begin
            int_n <= !(hsr_pend || other_irq);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            host_rdata <= 8'h00;
        end else if (rd_any) begin
            if (host_addr == OFS_CONTROL) begin
                host_rdata <= control;
            end else if (host_addr == OFS_STATUS) begin
                host_rdata <= hsr_val;
            end else if (host_addr == OFS_MASK) begin
                host_rdata <= event_mask;
            end else if (host_addr == OFS_RX_INFO) begin
                host_rdata <= rx_info_val;
            end else if (host_addr == OFS_RX_CODE) begin
                host_rdata <= rx_code_val;
            end else if (host_addr == OFS_TX_INFO) begin
                host_rdata <= tx_info_val;
            end else if (host_addr == OFS_TX_CODE) begin
                host_rdata <= code_ctl;
            end else begin
                host_rdata <= 8'h00;
            end
        end
    end

    // ==========================================================
    // Checks

    a_rt_read: assert property (@(posedge clk) disable iff (reset)
        (rd_any && host_addr == OFS_STATUS)
        |=> ((host_rdata & ~HSR_LATCH) == ($past(hsr_evt) & ~HSR_LATCH)))
        else $error("live status bits do not show the present condition");

    a_irq_assert: assert property (@(posedge clk) disable iff (reset)
        hsr_pend |=> !int_n)
        else $error("unmasked event did not pull the interrupt low");

    a_irq_release: assert property (@(posedge clk) disable iff (reset)
        (!hsr_pend && !other_irq) |=> int_n)
        else $error("interrupt held with no source pending");

    a_code_reset: assert property (@(posedge clk) disable iff (reset)
        (wr_ctl && host_wdata[CTL_RX_CODE_RST] && !control[CTL_RX_CODE_RST])
        |=> ##1 (rx_code_reset ##1 !rx_code_reset))
        else $error("code detect reset pulse wrong");

    a_abort_flush: assert property (@(posedge clk) disable iff (reset)
        (ctl_rise[CTL_ABORT] && !tx_in.valid) |=> (tx_abort && tx_fill == 5'h00))
        else $error("abort did not flush and signal");

    a_idle_sel: assert property (@(posedge clk) disable iff (reset)
        $changed(control[CTL_IDLE_SEL])
        |=> (idle_pattern == ($past(control[CTL_IDLE_SEL]) ? IDLE_ONES : FLAG_PATTERN)))
        else $error("idle pattern does not follow select");

    a_eom_clear: assert property (@(posedge clk) disable iff (reset)
        (tx_last_byte_sent && !wr_ctl) |=> !tx_end_of_message)
        else $error("end of message not cleared after last byte");

    a_pkt_end: assert property (@(posedge clk) disable iff (reset)
        ((rx_crc_error || rx_overrun || rx_abort_seen) && !wr_status)
        |=> u_hsr.latch[ST_PKT_END])
        else $error("packet end not latched on fault");

    a_tx_reset: assert property (@(posedge clk) disable iff (reset)
        ctl_rise[CTL_TX_PKT_RST] |=> (tx_packet_reset && !tx_byte_valid))
        else $error("transmit reset did not pulse and flush");

endmodule
`default_nettype wire

// >>> include/fhc_pkg.sv
package fhc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_STATUS  = 4'h1;
    localparam logic [3:0] OFS_MASK    = 4'h2;
    localparam logic [3:0] OFS_RX_INFO = 4'h3;
    localparam logic [3:0] OFS_RX_CODE = 4'h4;
    localparam logic [3:0] OFS_TX_INFO = 4'h5;
    localparam logic [3:0] OFS_TX_CODE = 4'h6;
    localparam logic [3:0] OFS_TX_DATA = 4'h7;

    // ==========================================================
    // Control fields and reset values
    localparam int CTL_RX_CODE_RST = 7;
    localparam int CTL_RX_PKT_RST  = 6;
    localparam int CTL_IDLE_SEL    = 5;
    localparam int CTL_TX_PKT_RST  = 4;
    localparam int CTL_ABORT       = 3;
    localparam int CTL_EOM         = 2;
    localparam int CTL_ZS_DEFEAT   = 1;
    localparam int CTL_CRC_DEFEAT  = 0;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] MASK_RST    = 8'h00;
    localparam logic [7:0] TX_CODE_RST = 8'h00;

    // ==========================================================
    // Status layouts; set bits mark latched positions
    localparam logic [7:0] HSR_LATCH     = 8'he1;
    localparam logic [7:0] RX_INFO_LATCH = 8'h00;
    localparam logic [7:0] RX_CODE_LATCH = 8'h80;
    localparam logic [7:0] TX_INFO_LATCH = 8'h10;
    localparam int ST_PKT_END = 6;

    // ==========================================================
    // Line patterns and transmit buffer
    localparam logic [7:0] FLAG_PATTERN = 8'h7e;
    localparam logic [7:0] IDLE_ONES    = 8'hff;
    localparam int         FIFO_WIDTH   = 8;
    localparam int         FIFO_DEPTH   = 16;
    localparam logic [4:0] FIFO_HALF    = 5'h08;

endpackage

// >>> include/fhc_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fhc_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport sink   (input valid, input data, output ready);
    modport source (output valid, output data, input ready);
endinterface
`default_nettype wire

// >>> verilog/fhc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module fhc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   flush,
    fhc_stream_if.sink                  wr,
    fhc_stream_if.source                rd,
    output logic [$clog2(DEPTH):0]      count
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   stored;
    logic          push;
    logic          pull;

    // Output stage is a register so the line side never sees a comb path
    assign wr.ready = (stored != DEPTH[AW:0]);
    assign push     = wr.valid && wr.ready;
    assign pull     = (stored != '0) && (!rd.valid || rd.ready);
    assign count    = stored + {{AW{1'b0}}, rd.valid};

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= wr.data;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wptr   <= '0;
            rptr   <= '0;
            stored <= '0;
        end else if (flush) begin
            wptr   <= '0;
            rptr   <= '0;
            stored <= '0;
        end else begin
            wptr   <= push ? wptr + 1'b1 : wptr;
            rptr   <= pull ? rptr + 1'b1 : rptr;
            stored <= stored + {{AW{1'b0}}, push} - {{AW{1'b0}}, pull};
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd.valid <= 1'b0;
            rd.data  <= '0;
        end else if (flush) begin
            rd.valid <= 1'b0;
        end else if (pull) begin
            rd.valid <= 1'b1;
            rd.data  <= mem[rptr];
        end else if (rd.ready) begin
            rd.valid <= 1'b0;
        end
    end

    a_full_refuse: assert property (@(posedge clk) disable iff (reset)
        (stored == DEPTH[AW:0] && !pull && !flush) |=> (stored == DEPTH[AW:0] && !wr.ready))
        else $error("fifo full state lost without a pull");
endmodule
`default_nettype wire

// >>> verilog/fhc_status_cell.sv
`timescale 1ns/1ps
`default_nettype none
module fhc_status_cell #(
    parameter logic [7:0] LATCH_BITS = 8'h00
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] event_in,
    input  wire logic       mask_wr,
    input  wire logic [7:0] wmask,
    input  wire logic [7:0] irq_mask,
    output logic [7:0]      read_value,
    output logic            pending
);
    logic [7:0] latch;
    logic [7:0] image;

    // A new event wins over the clear of the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latch <= 8'h00;
        end else if (mask_wr) begin
            latch <= ((latch & ~wmask) | event_in) & LATCH_BITS;
        end else begin
            latch <= (latch | event_in) & LATCH_BITS;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            image <= 8'h00;
        end else if (mask_wr) begin
            image <= ((image & ~wmask) | (latch & wmask)) & LATCH_BITS;
        end
    end

    // Live bits bypass the image, so writes cannot touch them
    assign read_value = image | (event_in & ~LATCH_BITS);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pending <= 1'b0;
        end else begin
            pending <= |((latch | (event_in & ~LATCH_BITS)) & irq_mask);
        end
    end

    a_latch_hold: assert property (@(posedge clk) disable iff (reset)
        !mask_wr |=> ((latch & $past(latch)) == $past(latch)))
        else $error("latched bit dropped without a mask write");

    a_mask_load: assert property (@(posedge clk) disable iff (reset)
        mask_wr |=> ((image & $past(wmask)) == ($past(latch) & $past(wmask))))
        else $error("image not loaded from latch on mask write");

    a_event_kept: assert property (@(posedge clk) disable iff (reset)
        (mask_wr && |(event_in & LATCH_BITS))
        |=> ((latch & $past(event_in)) == ($past(event_in) & LATCH_BITS)))
        else $error("event during mask write was lost");
endmodule
`default_nettype wire

// >>> dv/fhc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fhc_host_model (
    input  wire logic       clk,
    output logic            host_sel,
    output logic            host_wr,
    output logic            host_rd,
    output logic [3:0]      host_addr,
    output logic [7:0]      host_wdata,
    input  wire logic [7:0] host_rdata
);
    initial begin
        host_sel = 1'b0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = 4'hf;
        host_wdata = 8'h00;
    end
    // Released bus shows inverted data so a stale value never looks valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        {host_sel, host_wr, host_addr, host_wdata} = {2'b11, a, d};
        @(posedge clk);
        #1;
        {host_sel, host_wr, host_addr, host_wdata} = {2'b00, ~a, ~d};
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        {host_sel, host_rd, host_addr} = {2'b11, a};
        @(posedge clk);
        #1;
        {host_sel, host_rd, host_addr} = {2'b00, ~a};
        d = host_rdata;
    endtask
    task automatic poll(input logic [3:0] a, input logic [7:0] m, output logic [7:0] d);
        wr(a, m);
        rd(a, d);
        wr(a, d & m);
    endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk, reset, host_sel, host_wr, host_rd, int_n, tx_byte_valid, eom, zsd, crcd;
    logic        fdl, sbc;
    logic [3:0]  host_addr, pls;
    logic [5:0]  code, tcode;
    logic [7:0]  host_wdata, host_rdata, tx_byte, idle_pattern, r;
    logic [15:0] ev;
    int          fails, n_checks, np, nexp, cyc;
    logic [7:0]  rows [4][4] = '{'{8'h00, 8'h7e, 8'h00, 8'h00}, '{8'h20, 8'hff, 8'h00, 8'h00},
                                 '{8'h02, 8'h7e, 8'h01, 8'h00}, '{8'h01, 8'h7e, 8'h00, 8'h01}};
    fhc_host_model fhc_host_model_i (.clk(clk), .host_sel(host_sel), .host_wr(host_wr),
        .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata));
    fhc_host_ctrl fhc_host_ctrl_i (.clk(clk), .reset(reset), .host_sel(host_sel),
        .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .int_n(int_n), .other_irq(ev[14]), .rx_packet_start(ev[0]),
        .rx_msg_good(ev[1]), .rx_crc_error(ev[2]), .rx_overrun(ev[3]), .rx_abort_seen(ev[4]),
        .rx_fifo_half_full(ev[5]), .rx_fifo_not_empty(ev[6]), .rx_fifo_empty(ev[7]),
        .opening_byte_flag(ev[8]), .closing_byte_flag(ev[9]), .packet_good(ev[10]),
        .code_detect_live(ev[11]), .rx_code(code), .tx_last_byte_sent(ev[12]),
        .tx_underrun(ev[13]), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
        .tx_byte_ready(ev[15]), .rx_code_reset(pls[3]), .rx_packet_reset(pls[2]),
        .tx_packet_reset(pls[1]), .tx_abort(pls[0]), .idle_pattern(idle_pattern),
        .tx_end_of_message(eom), .zero_stuff_defeat(zsd), .crc_gen_defeat(crcd),
        .tx_code(tcode), .fdl_enable(fdl), .send_code(sbc));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input int b);
        tick(1);
        ev[b] = 1'b1;
        tick(1);
        ev[b] = 1'b0;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Strobes and taken bytes are sampled mid-cycle, away from the launching edge
    always @(negedge clk) begin
        np <= np + int'(pls[0]) + int'(pls[1]) + int'(pls[2]) + int'(pls[3]);
        if (tx_byte_valid === 1'b1 && ev[15]) begin
            chk(tx_byte, 8'(nexp), "fifo order");
            nexp++;
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        {reset, ev, code, fails, n_checks, np, nexp, cyc} = '0;
        reset = 1'b1;
        tick(8);
        reset = 1'b0;
        chk({7'h00, int_n}, 8'h01, "int idle");
        fhc_host_model_i.rd(4'h2, r);
        chk(r, 8'h00, "mask reset");
        foreach (rows[i]) begin
            fhc_host_model_i.wr(4'h0, rows[i][0]);
            tick(1);
            chk(idle_pattern, rows[i][1], "idle");
            chk({7'h00, zsd}, rows[i][2], "zero stuff");
            chk({7'h00, crcd}, rows[i][3], "crc");
        end
        // Pulse bits are 3, 4, 6 and 7; bit 5 selects idle and never pulses
        for (int i = 0; i < 4; i++) begin
            fhc_host_model_i.wr(4'h0, 8'h00);
            fhc_host_model_i.wr(4'h0, 8'h08 << (i < 2 ? i : i + 1));
            tick(3);
            fhc_host_model_i.wr(4'h0, 8'h08 << (i < 2 ? i : i + 1));
            tick(3);
            chk(8'(np), 8'(i + 1), "one pulse");
        end
        fhc_host_model_i.wr(4'h0, 8'h00);
        fhc_host_model_i.wr(4'h2, 8'h20);
        pulse(0);
        tick(2);
        chk({7'h00, int_n}, 8'h00, "int low");
        fhc_host_model_i.poll(4'h1, 8'h20, r);
        chk(r, 8'h26, "latched start");
        tick(2);
        chk({7'h00, int_n}, 8'h01, "int release");
        fhc_host_model_i.poll(4'h1, 8'h20, r);
        chk(r, 8'h06, "cleared");
        ev[14] = 1'b1;
        tick(3);
        chk({7'h00, int_n}, 8'h00, "other source");
        ev[14] = 1'b0;
        for (int b = 1; b < 5; b++) begin
            pulse(b);
            fhc_host_model_i.poll(4'h1, 8'h40, r);
            chk(r, 8'h46, "packet end cause");
        end
        ev[6] = 1'b1;
        fhc_host_model_i.poll(4'h1, 8'h00, r);
        chk(r, 8'h0e, "live bit");
        ev[6] = 1'b0;
        code = 6'h2b;
        ev[11] = 1'b1;
        fhc_host_model_i.poll(4'h4, 8'h80, r);
        chk(r, 8'heb, "code seen");
        fhc_host_model_i.poll(4'h1, 8'h80, r);
        chk(r, 8'h86, "code change");
        ev[11] = 1'b0;
        fhc_host_model_i.poll(4'h1, 8'h80, r);
        chk(r, 8'h86, "code ceased");
        fhc_host_model_i.poll(4'h4, 8'h80, r);
        chk(r, 8'h2b, "code gone");
        ev[10:7] = 4'b1110;
        fhc_host_model_i.rd(4'h3, r);
        chk(r, 8'h0e, "rx flags");
        ev[10:7] = 4'b0001;
        fhc_host_model_i.rd(4'h3, r);
        chk(r, 8'h01, "rx empty");
        fhc_host_model_i.wr(4'h6, 8'h6b);
        chk({sbc, fdl, tcode}, 8'h6b, "code armed");
        fhc_host_model_i.wr(4'h6, 8'heb);
        fhc_host_model_i.rd(4'h6, r);
        chk({sbc, fdl, tcode}, 8'heb, "code sent");
        chk(r, 8'heb, "code readback");
        fhc_host_model_i.wr(4'h0, 8'h04);
        pulse(12);
        tick(1);
        chk({7'h00, eom}, 8'h00, "eom self clear");
        fhc_host_model_i.poll(4'h1, 8'h01, r);
        chk(r, 8'h07, "message end");
        pulse(13);
        fhc_host_model_i.poll(4'h5, 8'h10, r);
        chk(r, 8'h17, "underrun latched");
        for (int i = 0; i < 18; i++) fhc_host_model_i.wr(4'h7, 8'(i));
        fhc_host_model_i.poll(4'h5, 8'h00, r);
        chk(r, 8'h08, "fifo full");
        ev[15] = 1'b1;
        tick(24);
        chk(8'(nexp), 8'd17, "drain count");
        fhc_host_model_i.poll(4'h5, 8'h00, r);
        chk(r, 8'h07, "fifo empty");
        end_sim();
    end
endmodule
`default_nettype wire
